// ---- pkg/xbpm_pkg.sv ----
/*
  xbpm_pkg: constants and carrier types for the external bus port mux.
  assumes a 32-bit apb register bus and a single core clock domain.
*/
package xbpm_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [15:0] XBPM_SEL_OFF     = 16'h6c00;
  localparam logic [15:0] XBPM_TOCTL_OFF   = 16'h6c04;
  localparam logic [15:0] XBPM_IRQ_STS_OFF = 16'h6c08;
  localparam logic [15:0] XBPM_IRQ_MSK_OFF = 16'h6c0c;
  localparam int          XBPM_MODE_BIT    = 0;
  localparam int          XBPM_RSV2_BIT    = 2;
  localparam int          XBPM_RSV3_BIT    = 3;
  localparam int          XBPM_TOEN_BIT    = 0;
  localparam int          XBPM_EV_DISACC   = 0;
  localparam int          XBPM_EV_SELWR    = 1;
  localparam logic [15:0] XBPM_SEL_RW_MASK = 16'h000d;
  localparam logic        XBPM_TOEN_RST    = 1'b0;
  localparam logic [1:0]  XBPM_IRQ_RST     = 2'b00;
  // ------------------------------------------------------------
  // pin widths
  // ------------------------------------------------------------
  localparam int XBPM_NADDR = 20;
  localparam int XBPM_NDATA = 32;
  localparam int XBPM_NCTRL = 16;
  localparam int XBPM_NHD   = 8;
  localparam int XBPM_NGPIO = 46;
  localparam int XBPM_GP_A  = 0;
  localparam int XBPM_GP_D  = 4;
  localparam int XBPM_GP_C  = 20;
  localparam int XBPM_GP_HD = 36;
  localparam int XBPM_GP_HA = 44;
  localparam int XBPM_GP_HB = 45;

  typedef struct packed {
    logic [XBPM_NADDR-1:0] addr;
    logic [XBPM_NDATA-1:0] data;
    logic [XBPM_NCTRL-1:0] ctrl;
  } xbpm_par_t;

  typedef struct packed {
    logic [XBPM_NHD-1:0] data;
    logic                ctl_a;
    logic                ctl_b;
  } xbpm_host_t;
endpackage

// ---- logic/xbpm_top.sv ----
/*
  xbpm_top: strap-selected routing of the parallel and host pin groups between
  the memory interface / host port and parallel general-purpose i/o, with the
  selection register, memory interface clock gate and disabled-module bus error.
  assumes synchronous pins, apb master on core_clk, strap stable at reset release.
*/
// Local design decision: the APB register port.
// Notes on behaviour
// RULE1: host group has eight data and two control pins, routed by mode bit.
// RULE2: strap low at reset: host pins to gpio, both interfaces off, mode 0.
// RULE3: strap high: host data to port, pin a strobe, pin b byte ident.
// RULE4: gpio mode maps host data to lines 36-43, controls to 44 and 45.
// RULE5: selection bit 0 loads from strap at reset, governs both groups.
// RULE6: mode 1 enables memory interface and connects address, data, control pins.
// RULE7: mode 0 keeps host port and memory interface deaf to pin activity.
// RULE8: memory interface clock gated off unless selected.
// RULE9: access to disabled module gives bus error when timeout enable set.
// RULE10: software writes zero to reserved bits 3 and 2; both are read/write.
// RULE11: software must not change mode after reset release.
// RULE12: gpio mode: address 2-17 and data 0-15 become reserved.
// RULE13: gpio mode maps address 18-21, data 16-31, controls 0-15 to gpio lines.
`timescale 1ns/100ps
module xbpm_top (
  input  wire logic                              core_clk,
  input  wire logic                              resetn,
  input  wire logic                              mux_strap_pin,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [15:0]                       paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  output logic                                   irq,
  input  wire logic                              mod_sel,
  input  wire logic                              mod_is_host,
  output logic                                   mod_bus_error,
  input  wire xbpm_pkg::xbpm_par_t               par_pin_in,
  output xbpm_pkg::xbpm_par_t                    par_pin_out,
  output xbpm_pkg::xbpm_par_t                    par_pin_oe,
  input  wire xbpm_pkg::xbpm_host_t              host_pin_in,
  output xbpm_pkg::xbpm_host_t                   host_pin_out,
  output xbpm_pkg::xbpm_host_t                   host_pin_oe,
  input  wire xbpm_pkg::xbpm_par_t               mem_if_out,
  input  wire xbpm_pkg::xbpm_par_t               mem_if_oe,
  output xbpm_pkg::xbpm_par_t                    mem_if_in,
  output logic                                   mem_if_clk_en,
  input  wire logic [xbpm_pkg::XBPM_NHD-1:0]     host_port_out,
  input  wire logic [xbpm_pkg::XBPM_NHD-1:0]     host_port_oe,
  output logic      [xbpm_pkg::XBPM_NHD-1:0]     host_port_in,
  output logic                                   host_address_strobe,
  output logic                                   host_byte_ident,
  output logic                                   host_port_en,
  input  wire logic [xbpm_pkg::XBPM_NGPIO-1:0]   parallel_gp_io_out,
  input  wire logic [xbpm_pkg::XBPM_NGPIO-1:0]   parallel_gp_io_oe,
  output logic      [xbpm_pkg::XBPM_NGPIO-1:0]   parallel_gp_io_in
);
  import xbpm_pkg::*;

  // ------------------------------------------------------------
  // strap capture and register declarations
  // ------------------------------------------------------------
  logic        strap_done_reg;
  logic        mode_reg;
  logic [3:2]  rsv_reg;
  logic        toen_reg;
  logic [1:0]  sts_reg;
  logic [1:0]  msk_reg;

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire         acc      = psel & penable & ~pready;
  wire         xfer_done = psel & penable & pready;
  wire         wr_acc   = xfer_done & pwrite;
  wire         hit_sel  = (paddr == XBPM_SEL_OFF);
  wire         hit_to   = (paddr == XBPM_TOCTL_OFF);
  wire         hit_sts  = (paddr == XBPM_IRQ_STS_OFF);
  wire         hit_msk  = (paddr == XBPM_IRQ_MSK_OFF);
  wire         hit_any  = hit_sel | hit_to | hit_sts | hit_msk;
  wire [31:0]  sel_val  = {28'h000_0000, rsv_reg, 1'b0, mode_reg};
  wire [31:0]  rd_val   = hit_sel ? sel_val :
                          hit_to  ? {31'h0000_0000, toen_reg} :
                          hit_sts ? {30'h0000_0000, sts_reg} :
                          hit_msk ? {30'h0000_0000, msk_reg} : 32'h0000_0000;
  wire         wr_sel   = wr_acc & hit_sel;
  wire         mode_chg = wr_sel & (pwdata[XBPM_MODE_BIT] != mode_reg);

  // module accesses while the mux leaves that module disabled
  wire         dis_acc  = mod_sel & ~mode_reg; // RULE7
  wire [1:0]   ev;
  assign ev[XBPM_EV_DISACC] = dis_acc;
  assign ev[XBPM_EV_SELWR]  = mode_chg;
  wire [1:0]   sts_clr  = (wr_acc & hit_sts) ? pwdata[1:0] : 2'b00;
  wire [1:0]   sts_next = (sts_reg & ~sts_clr) | ev;

  // ------------------------------------------------------------
  // register next values
  // ------------------------------------------------------------
  wire         mode_next    = !strap_done_reg ? mux_strap_pin : // RULE5 RULE2
                              wr_sel ? pwdata[XBPM_MODE_BIT] : mode_reg;
  wire [3:2]   rsv_next     = wr_sel ? pwdata[XBPM_RSV3_BIT:XBPM_RSV2_BIT] : rsv_reg; // RULE10
  wire         toen_next    = (wr_acc & hit_to) ? pwdata[XBPM_TOEN_BIT] : toen_reg;
  wire [1:0]   msk_next     = (wr_acc & hit_msk) ? pwdata[1:0] : msk_reg;
  wire         irq_next     = |(sts_next & msk_next);
  wire [31:0]  prdata_next  = (acc & ~pwrite) ? rd_val : 32'h0000_0000;
  wire         pslverr_next = acc & ~hit_any;
  wire         bus_err_next = dis_acc & toen_reg; // RULE9

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      strap_done_reg <= 1'b0;
      mode_reg       <= 1'b0;
    end else begin
      strap_done_reg <= 1'b1;
      mode_reg       <= mode_next; // RULE5 RULE2
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rsv_reg <= 2'b00;
    end else begin
      rsv_reg <= rsv_next; // RULE10
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      toen_reg <= XBPM_TOEN_RST;
    end else begin
      toen_reg <= toen_next;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      msk_reg <= XBPM_IRQ_RST;
    end else begin
      msk_reg <= msk_next;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sts_reg <= XBPM_IRQ_RST;
    end else begin
      sts_reg <= sts_next;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_next;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
    end else begin
      pready <= acc;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= pslverr_next;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= prdata_next;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mod_bus_error <= 1'b0;
    end else begin
      mod_bus_error <= bus_err_next; // RULE9
    end
  end

  // ------------------------------------------------------------
  // pin routing
  // ------------------------------------------------------------
  xbpm_par_t  gp_par_out;
  xbpm_par_t  gp_par_oe;
  xbpm_host_t gp_host_out;
  xbpm_host_t gp_host_oe;
  xbpm_host_t hp_out;
  xbpm_host_t hp_oe;

  assign gp_par_out.addr  = {parallel_gp_io_out[XBPM_GP_A +: 4], 16'h0000}; // RULE13 RULE12
  assign gp_par_oe.addr   = {parallel_gp_io_oe[XBPM_GP_A +: 4], 16'h0000};
  assign gp_par_out.data  = {parallel_gp_io_out[XBPM_GP_D +: 16], 16'h0000}; // RULE13 RULE12
  assign gp_par_oe.data   = {parallel_gp_io_oe[XBPM_GP_D +: 16], 16'h0000};
  assign gp_par_out.ctrl  = parallel_gp_io_out[XBPM_GP_C +: 16]; // RULE13
  assign gp_par_oe.ctrl   = parallel_gp_io_oe[XBPM_GP_C +: 16];
  assign gp_host_out      = {parallel_gp_io_out[XBPM_GP_HD +: 8], parallel_gp_io_out[XBPM_GP_HA],
                             parallel_gp_io_out[XBPM_GP_HB]}; // RULE4
  assign gp_host_oe       = {parallel_gp_io_oe[XBPM_GP_HD +: 8], parallel_gp_io_oe[XBPM_GP_HA],
                             parallel_gp_io_oe[XBPM_GP_HB]};
  assign hp_out           = {host_port_out, 2'b00}; // RULE3
  assign hp_oe            = {host_port_oe, 2'b00};

  xbpm_par_t              par_out_next;
  xbpm_par_t              par_oe_next;
  xbpm_host_t             host_out_next;
  xbpm_host_t             host_oe_next;
  xbpm_par_t              mem_in_next;
  logic [XBPM_NHD-1:0]    hp_in_next;
  logic [XBPM_NGPIO-1:0]  gpio_in_next;

  assign par_out_next  = mode_reg ? mem_if_out : gp_par_out; // RULE6
  assign par_oe_next   = mode_reg ? mem_if_oe : gp_par_oe;
  assign host_out_next = mode_reg ? hp_out : gp_host_out; // RULE1
  assign host_oe_next  = mode_reg ? hp_oe : gp_host_oe;
  assign mem_in_next   = mode_reg ? par_pin_in : '0; // RULE7
  assign hp_in_next    = mode_reg ? host_pin_in.data : '0; // RULE3 RULE7
  assign gpio_in_next  = mode_reg ? '0 :
                         {host_pin_in.ctl_b, host_pin_in.ctl_a, host_pin_in.data,
                          par_pin_in.ctrl, par_pin_in.data[31:16], par_pin_in.addr[19:16]}; // RULE4 RULE13

  // ------------------------------------------------------------
  // pin registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      par_pin_out <= '0;
    end else begin
      par_pin_out <= par_out_next; // RULE6
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      par_pin_oe <= '0;
    end else begin
      par_pin_oe <= par_oe_next; // RULE12
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      host_pin_out <= '0;
    end else begin
      host_pin_out <= host_out_next; // RULE1
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      host_pin_oe <= '0;
    end else begin
      host_pin_oe <= host_oe_next;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mem_if_in <= '0;
    end else begin
      mem_if_in <= mem_in_next; // RULE7
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mem_if_clk_en <= 1'b0;
    end else begin
      mem_if_clk_en <= mode_reg; // RULE8
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      host_port_in <= '0;
    end else begin
      host_port_in <= hp_in_next; // RULE3 RULE7
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      host_address_strobe <= 1'b0;
    end else begin
      host_address_strobe <= mode_reg & host_pin_in.ctl_a; // RULE3
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      host_byte_ident <= 1'b0;
    end else begin
      host_byte_ident <= mode_reg & host_pin_in.ctl_b; // RULE3
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      host_port_en <= 1'b0;
    end else begin
      host_port_en <= mode_reg; // RULE2
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      parallel_gp_io_in <= '0;
    end else begin
      parallel_gp_io_in <= gpio_in_next; // RULE4 RULE13
    end
  end
endmodule // xbpm_top

// ---- dv/xbpm_pin_model.sv ----
/* pin model: far side of both pin groups.
   assumes oe high means the device drives the pin. */
`timescale 1ns/100ps
module xbpm_pin_model
  import xbpm_pkg::*;
(
  input  wire logic       core_clk,
  input  wire xbpm_par_t  par_pin_out,
  input  wire xbpm_par_t  par_pin_oe,
  input  wire xbpm_host_t host_pin_out,
  input  wire xbpm_host_t host_pin_oe,
  output xbpm_par_t       par_pin_in,
  output xbpm_host_t      host_pin_in
);
  logic [95:0] drv;
  initial drv = '0;
  always @(posedge core_clk) drv <= {$urandom, $urandom, $urandom};
  // driven pins read back, released ones carry a pattern that changes each cycle
  assign par_pin_in  = (par_pin_oe & par_pin_out) | (~par_pin_oe & drv[67:0]);
  assign host_pin_in = (host_pin_oe & host_pin_out) | (~host_pin_oe & drv[77:68]);
endmodule // xbpm_pin_model

// ---- dv/xbpm_top_assertions.sv ----
/* checker: routing, gating and bus error seen at the top ports.
   assumes one clock domain and binding to xbpm_top. */
`timescale 1ns/100ps
module xbpm_top_assertions
  import xbpm_pkg::*;
(
  input wire logic                  core_clk,
  input wire logic                  resetn,
  input wire logic                  mod_sel,
  input wire logic                  mod_bus_error,
  input wire xbpm_par_t             par_pin_out,
  input wire xbpm_par_t             par_pin_oe,
  input wire xbpm_host_t            host_pin_out,
  input wire xbpm_host_t            host_pin_in,
  input wire logic                  host_address_strobe,
  input wire logic                  host_byte_ident,
  input wire xbpm_par_t             mem_if_out,
  input wire xbpm_par_t             mem_if_in,
  input wire logic                  mem_if_clk_en,
  input wire logic [XBPM_NHD-1:0]   host_port_out,
  input wire logic [XBPM_NHD-1:0]   host_port_in,
  input wire logic                  host_port_en,
  input wire logic [XBPM_NGPIO-1:0] parallel_gp_io_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence host_mode; mem_if_clk_en && $past(resetn); endsequence
  sequence gpio_mode; !mem_if_clk_en && $past(resetn); endsequence
  mem_route_a: assert property (host_mode |-> par_pin_out == $past(mem_if_out))
    else $error("memory route");
  host_route_a: assert property (host_mode |-> host_pin_out.data == $past(host_port_out))
    else $error("host route");
  host_gpio_a: assert property (gpio_mode |-> host_pin_out.data == $past(parallel_gp_io_out[43:36])
    && host_pin_out.ctl_a == $past(parallel_gp_io_out[44]) && host_pin_out.ctl_b == $past(parallel_gp_io_out[45]))
    else $error("host gpio route");
  strobe_route_a: assert property (host_mode |-> host_address_strobe == $past(host_pin_in.ctl_a)
    && host_byte_ident == $past(host_pin_in.ctl_b))
    else $error("host strobe route");
  par_gpio_a: assert property (gpio_mode |-> par_pin_out.ctrl == $past(parallel_gp_io_out[35:20]))
    else $error("parallel gpio route");
  rsvd_pins_a: assert property (gpio_mode |-> par_pin_oe.addr[15:0] == 0 && par_pin_oe.data[15:0] == 0)
    else $error("reserved pin driven");
  deaf_a: assert property (!mem_if_clk_en |-> mem_if_in == 0 && host_port_in == 0 && !host_port_en)
    else $error("disabled module sees pins");
  clk_gate_a: assert property (mem_if_clk_en == host_port_en)
    else $error("clock gate");
  bus_err_a: assert property (mod_bus_error |-> $past(mod_sel) && !mem_if_clk_en)
    else $error("bus error cause");
endmodule // xbpm_top_assertions
bind xbpm_top xbpm_top_assertions chk_u (.core_clk(core_clk), .resetn(resetn), .mod_sel(mod_sel),
  .mod_bus_error(mod_bus_error), .par_pin_out(par_pin_out), .par_pin_oe(par_pin_oe), .host_pin_out(host_pin_out),
  .mem_if_out(mem_if_out), .mem_if_in(mem_if_in), .mem_if_clk_en(mem_if_clk_en), .host_port_out(host_port_out),
  .host_port_in(host_port_in), .host_port_en(host_port_en), .parallel_gp_io_out(parallel_gp_io_out),
  .host_pin_in(host_pin_in), .host_address_strobe(host_address_strobe), .host_byte_ident(host_byte_ident));

// ---- dv/tb_xbpm_top.sv ----
/* bench: both strap levels, routing, registers, bus error and irq.
   assumes the pin model and the bound checker. */
`timescale 1ns/100ps
module tb_xbpm_top;
  import xbpm_pkg::*;
  logic         core_clk, resetn, mux_strap_pin, psel, penable, pwrite, mod_sel, e, pready, pslverr, irq;
  logic         mod_bus_error, mem_if_clk_en, host_address_strobe, host_byte_ident, host_port_en;
  logic [15:0]  paddr;
  logic [31:0]  pwdata, prdata, r;
  logic [7:0]   hp_out, hp_oe, hp_in;
  logic [45:0]  gp_out, gp_oe, gp_in;
  logic [127:0] rnd;
  xbpm_par_t    par_in, par_out, par_oe, mem_out, mem_oe, mem_in, sp;
  xbpm_host_t   host_in, host_out, host_oe, sh;
  int           fail_count, total_checks;
  xbpm_top dut_u (.core_clk(core_clk), .resetn(resetn), .mux_strap_pin(mux_strap_pin), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .mod_sel(mod_sel), .mod_is_host(1'b0), .mod_bus_error(mod_bus_error),
    .par_pin_in(par_in), .par_pin_out(par_out), .par_pin_oe(par_oe), .host_pin_in(host_in), .host_pin_out(host_out),
    .host_pin_oe(host_oe), .mem_if_out(mem_out), .mem_if_oe(mem_oe), .mem_if_in(mem_in), .mem_if_clk_en(mem_if_clk_en),
    .host_port_out(hp_out), .host_port_oe(hp_oe), .host_port_in(hp_in), .host_address_strobe(host_address_strobe),
    .host_byte_ident(host_byte_ident), .host_port_en(host_port_en), .parallel_gp_io_out(gp_out),
    .parallel_gp_io_oe(gp_oe), .parallel_gp_io_in(gp_in));
  xbpm_pin_model far_u (.core_clk(core_clk), .par_pin_out(par_out), .par_pin_oe(par_oe), .host_pin_out(host_out),
    .host_pin_oe(host_oe), .par_pin_in(par_in), .host_pin_in(host_in));
  always #12.5 core_clk = ~core_clk;
  task automatic chk(input logic [319:0] s, input logic [319:0] x);
    total_checks++;
    if (s !== x) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, x);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function automatic xbpm_par_t exp_par(input logic m, input logic [45:0] g, input xbpm_par_t v);
    if (m) return v;
    return {g[3:0], 16'h0000, g[19:4], 16'h0000, g[35:20]};
  endfunction
  initial begin
    repeat (4000) @(posedge core_clk);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    {core_clk, resetn, mux_strap_pin, psel, penable, pwrite, mod_sel, paddr, pwdata} = '0;
    {hp_out, hp_oe, gp_out, gp_oe, mem_out, mem_oe} = '0;
    void'($urandom(32'h5768_803d));
    for (int m = 0; m < 2; m++) begin
      mux_strap_pin <= m[0];
      resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge core_clk);
      apb(0, XBPM_SEL_OFF, 0); chk(r, m);
      apb(1, XBPM_SEL_OFF, m); apb(0, XBPM_SEL_OFF, 0); chk(r, m);
      apb(0, 16'h6c10, 0); chk(e, 1);
      repeat (20) begin
        rnd = {$urandom, $urandom, $urandom, $urandom};
        {hp_out, gp_out, mem_out} <= rnd[121:0];
        rnd = {$urandom, $urandom, $urandom, $urandom};
        {hp_oe, gp_oe, mem_oe} <= rnd[121:0];
        @(posedge core_clk);
        {sp, sh} = {par_in, host_in};
        @(posedge core_clk);
        chk({par_out, par_oe}, {exp_par(m, gp_out, mem_out), exp_par(m, gp_oe, mem_oe)});
        chk(host_out.data, m ? hp_out : gp_out[43:36]);
        chk({host_out, host_oe}, m ? {hp_out, 2'b00, hp_oe, 2'b00} : {gp_out[43:36], gp_out[44], gp_out[45],
          gp_oe[43:36], gp_oe[44], gp_oe[45]});
        chk(gp_in, m ? 46'h0 : {sh.ctl_b, sh.ctl_a, sh.data, sp.ctrl, sp.data[31:16], sp.addr[19:16]});
        chk({mem_in, hp_in, host_address_strobe, host_byte_ident, host_port_en, mem_if_clk_en},
          m ? {sp, sh.data, sh.ctl_a, sh.ctl_b, 2'b11} : 80'h0);
      end
      apb(1, XBPM_IRQ_MSK_OFF, 1);
      for (int t = 0; t < 2; t++) begin
        if (t == 1) apb(1, XBPM_TOCTL_OFF, 1);
        mod_sel <= 1'b1;
        @(posedge core_clk);
        mod_sel <= 1'b0;
        @(posedge core_clk);
        chk(mod_bus_error, t == 1 && m == 0);
      end
      apb(0, XBPM_IRQ_STS_OFF, 0); chk({r[0], irq}, {2{!m}});
      apb(1, XBPM_IRQ_STS_OFF, 3); repeat (2) @(posedge core_clk); chk(irq, 0);
    end
    tally_and_finish();
  end
endmodule // tb_xbpm_top
